// ==== pcr_pkg.sv ====
/*
 * Package for the post-processing and clock recovery register slice.
 * It holds register offsets, reset values, field positions and the packed
 * carriers shared by the register bank and its pixel status unit.
 * Assumes an 8-bit register address space served by the host interface.
 */
package pcr_pkg;

   // ==========================================================================
   // Register offsets
   // ==========================================================================
   localparam logic [7:0] PCR_ADDR_RED    = 8'h3e; // Red post-processing value.
   localparam logic [7:0] PCR_ADDR_GREEN  = 8'h3f; // Green post-processing value.
   localparam logic [7:0] PCR_ADDR_BLUE   = 8'h40; // Blue post-processing value.
   localparam logic [7:0] PCR_ADDR_BRIGHT = 8'h41; // Brightness adjustment amount.
   localparam logic [7:0] PCR_ADDR_CMPREF = 8'h42; // Pixel comparison reference.
   localparam logic [7:0] PCR_ADDR_STATUS = 8'h43; // Compare and brightness status.
   localparam logic [7:0] PCR_ADDR_CRCTL  = 8'h44; // Clock recovery control.
   localparam logic [7:0] PCR_ADDR_PHOFS  = 8'h45; // Calibrated phase offset.

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [7:0] PCR_RST_VALUE  = 8'h00; // Colour, brightness, reference.
   localparam logic [7:0] PCR_RST_CRCTL  = 8'h71; // Clock recovery control.
   localparam logic [3:0] PCR_RST_PHOFS  = 4'h0;  // Phase offset.

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int PCR_CR_DIV2   = 0; // Clock divisible by two.
   localparam int PCR_CR_DIV4   = 1; // Clock divisible by four.
   localparam int PCR_CR_DIV8   = 2; // Clock divisible by eight.
   localparam int PCR_CR_TRACK  = 3; // Phase tracking enable.
   localparam int PCR_CR_APHASE = 4; // Auto phase calibration enable.
   localparam int PCR_CR_AFREQ  = 5; // Auto frequency calibration enable.
   localparam int PCR_CR_AMODE  = 6; // Auto mode detection enable.
   localparam int PCR_CR_HALF   = 7; // Half clock speed, stored only.
   localparam int PCR_ST_BRIGHT = 2; // Brightness overflow or underflow.
   localparam int PCR_PHOFS_W   = 4; // Width of the phase offset field.

   // ==========================================================================
   // Comparison result codes
   // ==========================================================================
   typedef enum logic [1:0] {
      PCR_CMP_INVALID = 2'b00,
      PCR_CMP_ABOVE   = 2'b01,
      PCR_CMP_EQUAL   = 2'b10,
      PCR_CMP_BELOW   = 2'b11
   } pcr_cmp_t;

   // ==========================================================================
   // Carriers
   // ==========================================================================
   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } pcr_pixel_t;

   typedef struct packed {
      logic       wr;    // Write strobe, one cycle.
      logic       rd;    // Read strobe, one cycle.
      logic [7:0] addr;  // Register offset.
      logic [7:0] wdata; // Write data.
   } pcr_cfg_req_t;

   typedef struct packed {
      logic div2;
      logic div4;
      logic div8;
      logic phase_track_en;
      logic auto_phase_en;
      logic auto_freq_en;
      logic auto_mode_en;
   } pcr_recovery_t;

endpackage

// ==== pcr_pixel_status.sv ====
/*
 * Pixel status unit: compares the selected incoming pixel with the reference
 * and checks whether brightness adjustment leaves the component range.
 * Assumes the pixel pipeline presents one selected pixel per valid pulse on
 * the same clock.
 */
`timescale 1ns/1ps
module pcr_pixel_status #(
   parameter int CMP_CHAN = 1 // Component compared: 0 red, 1 green, 2 blue.
) (
   input  wire logic                 mclk_in,
   input  wire logic                 reset_in,
   input  wire logic                 pix_valid_in,
   input  wire pcr_pkg::pcr_pixel_t  pixel_in,
   input  wire logic                 bright_up_in,
   input  wire logic [7:0]           bright_amt_in,
   input  wire logic [7:0]           cmp_ref_in,
   output pcr_pkg::pcr_cmp_t         cmp_out,
   output logic                      bright_err_out
);
   import pcr_pkg::*;

   // Elaboration check: only the three colour components can be selected.
   if (CMP_CHAN < 0 || CMP_CHAN > 2) begin : g_bad_chan
      $error("CMP_CHAN must be 0, 1 or 2");
   end

   // ==========================================================================
   // Selected component
   // ==========================================================================
   logic [7:0]  sel_comp;  // Component under comparison.
   logic [2:0]  comp_err;  // Per-component range fault.
   logic [23:0] comp_flat; // Components, red in the top byte.
   pcr_cmp_t    cmp_d;     // Next comparison result.

   assign comp_flat = pixel_in;
   assign sel_comp  = comp_flat[8*(2-CMP_CHAN) +: 8];

   // One range check per component; a raised component that carries past 255
   // overflows, a lowered one smaller than the amount underflows.
   for (genvar i = 0; i < 3; i++) begin : g_range
      logic [8:0] sum;
      assign sum         = {1'b0, comp_flat[8*i +: 8]} + {1'b0, bright_amt_in};
      assign comp_err[i] = bright_up_in ? sum[8] : (comp_flat[8*i +: 8] < bright_amt_in);
   end

   // Comparison encoding.
   always_comb begin
      if (sel_comp > cmp_ref_in) begin
         cmp_d = PCR_CMP_ABOVE;
      end else if (sel_comp == cmp_ref_in) begin
         cmp_d = PCR_CMP_EQUAL;
      end else begin
         cmp_d = PCR_CMP_BELOW;
      end
   end

   // ==========================================================================
   // Result registers
   // ==========================================================================
   // Both results refresh on every selected pixel and otherwise hold, so
   // software always reads the outcome of the latest pixel seen.
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         cmp_out        <= PCR_CMP_INVALID;
         bright_err_out <= 1'b0;
      end else if (pix_valid_in) begin
         cmp_out        <= cmp_d;
         bright_err_out <= |comp_err;
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   property p_cmp_above;
      pix_valid_in && sel_comp > cmp_ref_in |=> cmp_out == PCR_CMP_ABOVE;
   endproperty
   a_cmp_above: assert property (p_cmp_above) else $error("compare above wrong");

   property p_cmp_below;
      pix_valid_in && sel_comp < cmp_ref_in |=> cmp_out == PCR_CMP_BELOW;
   endproperty
   a_cmp_below: assert property (p_cmp_below) else $error("compare below wrong");

   property p_bright_ovf;
      pix_valid_in && bright_up_in && ({1'b0, pixel_in.b} + {1'b0, bright_amt_in} > 9'h0ff)
         |=> bright_err_out;
   endproperty
   a_bright_ovf: assert property (p_bright_ovf) else $error("overflow not flagged");

   property p_bright_unf;
      pix_valid_in && !bright_up_in && (pixel_in.b < bright_amt_in) |=> bright_err_out;
   endproperty
   a_bright_unf: assert property (p_bright_unf) else $error("underflow not flagged");

   property p_cmp_equal;
      pix_valid_in && sel_comp == cmp_ref_in |=> cmp_out == PCR_CMP_EQUAL;
   endproperty
   a_cmp_equal: assert property (p_cmp_equal) else $error("compare equal wrong");

   property p_hold;
      !pix_valid_in |=> $stable(cmp_out) && $stable(bright_err_out);
   endproperty
   a_hold: assert property (p_hold) else $error("status changed without pixel");

endmodule

// ==== pcr_regs.sv ====
/*
 * Post-processing and clock recovery register bank.
 * Holds the colour values, brightness amount, compare reference, the status
 * register, clock recovery control and phase offset, and drives them to the
 * pixel pipeline and the clock recovery engine.
 * Assumes the host interface decoder issues single-cycle read and write
 * strobes on mclk_in, and the pixel pipeline shares that clock.
 */
// Notes on behaviour
// - Green post-processing value, 8-bit, resets zero.
// - Blue post-processing value, 8-bit, resets zero.
// - Brightness adjustment amount, 8-bit, resets zero.
// - Pixel comparison reference, 8-bit, resets zero.
// - Status bits 1:0 give compare outcome.
// - Status bit 2 flags brightness overflow/underflow.
// - Status register read-only; bits 7:3 reserved.
// - Clock recovery control resets to 71h.
// - Control bits 0-2: divisible by 2,4,8.
// - Phase tracking only while control bit 3.
// - Auto phase calibration only while bit 4.
// - Auto frequency calibration only while bit 5.
// - Auto mode detection only while bit 6.
// - Bit 7 half speed stored, no effect.
// - 4-bit phase offset added to calibrated phase.
// - Red post-processing value, 8-bit, resets zero.
`timescale 1ns/1ps
module pcr_regs #(
   parameter int CMP_CHAN = 1 // Component that the comparison looks at.
) (
   input  wire logic                  mclk_in,
   input  wire logic                  reset_in,
   // Host register access.
   input  wire pcr_pkg::pcr_cfg_req_t cfg_req_in,
   output logic [7:0]                 cfg_rdata_out,
   // Pixel pipeline.
   input  wire logic                  pix_valid_in,
   input  wire pcr_pkg::pcr_pixel_t   pixel_in,
   input  wire logic                  bright_up_in,
   output pcr_pkg::pcr_pixel_t        pp_value_out,
   output logic [7:0]                 bright_amt_out,
   // Clock recovery engine.
   input  wire logic [9:0]            cal_phase_in,
   output pcr_pkg::pcr_recovery_t     recovery_out,
   output logic [9:0]                 final_phase_out
);
   import pcr_pkg::*;

   // Elaboration check: only the three colour components can be compared.
   if (CMP_CHAN < 0 || CMP_CHAN > 2) begin : g_bad_chan
      $error("CMP_CHAN must be 0, 1 or 2");
   end

   // ==========================================================================
   // Storage
   // ==========================================================================
   logic [7:0]             red_q;     // Red post-processing value.
   logic [7:0]             green_q;   // Green post-processing value.
   logic [7:0]             blue_q;    // Blue post-processing value.
   logic [7:0]             bright_q;  // Brightness adjustment amount.
   logic [7:0]             cmpref_q;  // Comparison reference.
   logic [7:0]             crctl_q;   // Clock recovery control.
   logic [PCR_PHOFS_W-1:0] phofs_q;   // Calibrated phase offset.
   logic [7:0]             rdata_q;   // Read data holding register.
   logic [7:0]             rdata_d;   // Read data for the addressed register.
   logic [7:0]             status;    // Live status word.
   logic [9:0]             phase_q;   // Final phase after offset.
   pcr_cmp_t               cmp_res;   // Latest comparison result.
   logic                   bright_err; // Latest brightness range fault.
   logic                   wr;        // Write strobe.
   logic [7:0]             addr;      // Addressed offset.
   logic [7:0]             wdata;     // Write data.

   assign wr    = cfg_req_in.wr;
   assign addr  = cfg_req_in.addr;
   assign wdata = cfg_req_in.wdata;

   // ==========================================================================
   // Colour value registers
   // ==========================================================================
   // The three colour values feed advanced post processing directly.
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         red_q   <= PCR_RST_VALUE;
         green_q <= PCR_RST_VALUE;
         blue_q  <= PCR_RST_VALUE;
      end else if (wr) begin
         if (addr == PCR_ADDR_RED) begin
            red_q <= wdata;
         end
         if (addr == PCR_ADDR_GREEN) begin
            green_q <= wdata;
         end
         if (addr == PCR_ADDR_BLUE) begin
            blue_q <= wdata;
         end
      end
   end

   // ==========================================================================
   // Brightness and comparison reference
   // ==========================================================================
   // Both are used combinationally by the status unit in the next cycle.
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         bright_q <= PCR_RST_VALUE;
         cmpref_q <= PCR_RST_VALUE;
      end else if (wr) begin
         if (addr == PCR_ADDR_BRIGHT) begin
            bright_q <= wdata;
         end
         if (addr == PCR_ADDR_CMPREF) begin
            cmpref_q <= wdata;
         end
      end
   end

   // ==========================================================================
   // Clock recovery control and phase offset
   // ==========================================================================
   // The half speed bit is kept so software reads back what it wrote, but
   // nothing downstream uses it.
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         crctl_q <= PCR_RST_CRCTL;
         phofs_q <= PCR_RST_PHOFS;
      end else if (wr) begin
         if (addr == PCR_ADDR_CRCTL) begin
            crctl_q <= wdata;
         end
         if (addr == PCR_ADDR_PHOFS) begin
            phofs_q <= wdata[PCR_PHOFS_W-1:0];
         end
      end
   end

   // Enables gate the recovery engine's features; each feature may run only
   // while its bit is set.
   always_comb begin
      recovery_out.div2           = crctl_q[PCR_CR_DIV2];
      recovery_out.div4           = crctl_q[PCR_CR_DIV4];
      recovery_out.div8           = crctl_q[PCR_CR_DIV8];
      recovery_out.phase_track_en = crctl_q[PCR_CR_TRACK];
      recovery_out.auto_phase_en  = crctl_q[PCR_CR_APHASE];
      recovery_out.auto_freq_en   = crctl_q[PCR_CR_AFREQ];
      recovery_out.auto_mode_en   = crctl_q[PCR_CR_AMODE];
   end

   // Final phase is the calibrated phase plus the offset; it wraps within ten
   // bits, as the phase is itself a modular quantity.
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         phase_q <= 10'h000;
      end else begin
         phase_q <= 10'(cal_phase_in + {6'h00, phofs_q});
      end
   end

   assign final_phase_out = phase_q;

   // ==========================================================================
   // Pixel status unit
   // ==========================================================================
   pcr_pixel_status #(
      .CMP_CHAN (CMP_CHAN)
   ) u_status (
      .mclk_in        (mclk_in),
      .reset_in       (reset_in),
      .pix_valid_in   (pix_valid_in),
      .pixel_in       (pixel_in),
      .bright_up_in   (bright_up_in),
      .bright_amt_in  (bright_q),
      .cmp_ref_in     (cmpref_q),
      .cmp_out        (cmp_res),
      .bright_err_out (bright_err)
   );

   // Reserved status bits read as zero; writes to this offset do nothing.
   assign status = {5'h00, bright_err, cmp_res};

   // ==========================================================================
   // Read path
   // ==========================================================================
   // Unmapped offsets read as zero so a stray read is harmless.
   always_comb begin
      unique case (addr)
         PCR_ADDR_RED:    rdata_d = red_q;
         PCR_ADDR_GREEN:  rdata_d = green_q;
         PCR_ADDR_BLUE:   rdata_d = blue_q;
         PCR_ADDR_BRIGHT: rdata_d = bright_q;
         PCR_ADDR_CMPREF: rdata_d = cmpref_q;
         PCR_ADDR_STATUS: rdata_d = status;
         PCR_ADDR_CRCTL:  rdata_d = crctl_q;
         PCR_ADDR_PHOFS:  rdata_d = {4'h0, phofs_q};
         default:         rdata_d = 8'h00;
      endcase
   end

   // Read data is captured on the strobe and held until the next read.
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_q <= 8'h00;
      end else if (cfg_req_in.rd) begin
         rdata_q <= rdata_d;
      end
   end

   assign cfg_rdata_out  = rdata_q;
   assign pp_value_out   = {red_q, green_q, blue_q};
   assign bright_amt_out = bright_q;

   // ==========================================================================
   // Checks
   // ==========================================================================
   // All checks run on the register clock and rest while reset is held,
   // because the reset branch is what sets every register they watch.
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   // A write taken at one edge must show in its register at the next one.
   sequence s_write(logic [7:0] a);
      wr && addr == a;
   endsequence

   property p_green;
      s_write(PCR_ADDR_GREEN) |=> green_q == $past(wdata);
   endproperty
   a_green: assert property (p_green) else $error("green write lost");

   property p_blue;
      s_write(PCR_ADDR_BLUE) |=> blue_q == $past(wdata);
   endproperty
   a_blue: assert property (p_blue) else $error("blue write lost");

   property p_bright;
      s_write(PCR_ADDR_BRIGHT) |=> bright_amt_out == $past(wdata);
   endproperty
   a_bright: assert property (p_bright) else $error("brightness write lost");

   property p_cmpref;
      s_write(PCR_ADDR_CMPREF) ##1 cfg_req_in.rd && addr == PCR_ADDR_CMPREF
         |=> cfg_rdata_out == $past(wdata, 2);
   endproperty
   a_cmpref: assert property (p_cmpref) else $error("reference readback wrong");

   property p_red;
      s_write(PCR_ADDR_RED) |=> pp_value_out.r == $past(wdata);
   endproperty
   a_red: assert property (p_red) else $error("red write lost");

   property p_status_ro;
      cfg_req_in.rd && addr == PCR_ADDR_STATUS |=> cfg_rdata_out[7:3] == 5'h00;
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("reserved status bits set");

   property p_track;
      s_write(PCR_ADDR_CRCTL) |=> recovery_out.phase_track_en == $past(wdata[PCR_CR_TRACK])
         && recovery_out.auto_mode_en == $past(wdata[PCR_CR_AMODE]);
   endproperty
   a_track: assert property (p_track) else $error("control enables wrong");

   property p_half;
      s_write(PCR_ADDR_CRCTL) ##1 cfg_req_in.rd && addr == PCR_ADDR_CRCTL
         |=> cfg_rdata_out[PCR_CR_HALF] == $past(wdata[PCR_CR_HALF], 2);
   endproperty
   a_half: assert property (p_half) else $error("half speed bit not stored");

   property p_phase;
      $stable(phofs_q) |=> final_phase_out == 10'($past(cal_phase_in) + {6'h00, $past(phofs_q)});
   endproperty
   a_phase: assert property (p_phase) else $error("phase offset not applied");

   // Divisibility flags follow the written bits, lowest bit first.
   property p_divide;
      s_write(PCR_ADDR_CRCTL) |=> {recovery_out.div2, recovery_out.div4, recovery_out.div8}
         == {$past(wdata[PCR_CR_DIV2]), $past(wdata[PCR_CR_DIV4]), $past(wdata[PCR_CR_DIV8])};
   endproperty
   a_divide: assert property (p_divide) else $error("divisibility flags wrong");

   // Auto phase calibration may run only while its bit is set.
   property p_aphase;
      s_write(PCR_ADDR_CRCTL) |=> recovery_out.auto_phase_en == $past(wdata[PCR_CR_APHASE]);
   endproperty
   a_aphase: assert property (p_aphase) else $error("auto phase enable wrong");

   // Auto frequency calibration may run only while its bit is set.
   property p_afreq;
      s_write(PCR_ADDR_CRCTL) |=> recovery_out.auto_freq_en == $past(wdata[PCR_CR_AFREQ]);
   endproperty
   a_afreq: assert property (p_afreq) else $error("auto frequency enable wrong");

   // The control register leaves reset holding its power-on default.
   property p_ctl_reset;
      $fell(reset_in) |-> crctl_q == PCR_RST_CRCTL && phofs_q == PCR_RST_PHOFS;
   endproperty
   a_ctl_reset: assert property (p_ctl_reset) else $error("control reset value wrong");

   // A write aimed at the status offset must leave the status untouched.
   property p_status_wr;
      wr && addr == PCR_ADDR_STATUS && !pix_valid_in |=> $stable(status);
   endproperty
   a_status_wr: assert property (p_status_wr) else $error("status took a write");

endmodule

// ==== test_pcr_regs.sv ====
/*
 * Self-checking testbench for the post-processing and clock recovery register bank.
 * Assumes the package and the bank are compiled first; one 40 MHz clock, reset high.
 */
`timescale 1ns/1ps
module test_pcr_regs;
   import pcr_pkg::*;

   // ==========================================================================
   // Signals
   // ==========================================================================
   logic          mclk_in;   // Bench clock.
   logic          reset_in;  // Asynchronous reset, high.
   pcr_cfg_req_t  req;       // Host request.
   logic [7:0]    rdata;     // Read data seen.
   logic          pix_valid; // Selected pixel strobe.
   pcr_pixel_t    pix;       // Pixel under test.
   logic          up;        // Brightness direction.
   pcr_pixel_t    pp;        // Colour values out.
   logic [7:0]    amt;       // Brightness amount out.
   logic [9:0]    cal;       // Calibrated phase in.
   logic [9:0]    fin;       // Final phase out.
   pcr_recovery_t rec;       // Recovery enables out.
   int            err_count; // Mismatches.
   int            checks;    // Comparisons.
   logic [7:0]    q[$];      // Expected read data, oldest first.
   logic          rd_d;      // A read was taken at the last edge.
   logic [7:0]    seed;      // Random source state.
   logic [7:0]    d[8];      // Values written in the random pass.
   logic [7:0]    rst[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h71, 8'h00};
   logic [24:0]   cases[7];  // Pixel cases: {r, g, b, up}.

   pcr_regs #(.CMP_CHAN(1)) dut (
      .mclk_in(mclk_in), .reset_in(reset_in), .cfg_req_in(req), .cfg_rdata_out(rdata),
      .pix_valid_in(pix_valid), .pixel_in(pix), .bright_up_in(up), .pp_value_out(pp),
      .bright_amt_out(amt), .cal_phase_in(cal), .recovery_out(rec), .final_phase_out(fin)
   );

   // ==========================================================================
   // Clock and helpers
   // ==========================================================================
   // Free-running clock, 25 ns period.
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end

   // Shared comparison; unknown values never match.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Eight-bit shift register source, so runs repeat exactly.
   function automatic logic [7:0] lfsr();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction

   // Recovery enables in struct order: bit 0 lands in the top position.
   function automatic logic [6:0] rec_of(input logic [7:0] c);
      return {c[0], c[1], c[2], c[3], c[4], c[5], c[6]};
   endfunction

   // Status byte predicted from the green compare and the range of every component.
   function automatic logic [7:0] st_of(input logic [24:0] c, input logic [7:0] a, r);
      logic [1:0] cmp;
      logic       e;
      cmp = (c[16:9] > r) ? 2'h1 : (c[16:9] == r) ? 2'h2 : 2'h3;
      if (c[0]) e = ({1'b0, c[24:17]} + a > 9'h0ff) || ({1'b0, c[16:9]} + a > 9'h0ff)
                    || ({1'b0, c[8:1]} + a > 9'h0ff);
      else e = (c[24:17] < a) || (c[16:9] < a) || (c[8:1] < a);
      return {5'h00, e, cmp};
   endfunction

   // Each request is raised after one edge and taken at the next.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk_in);
      req <= '{1'b1, 1'b0, a, v};
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      req <= '{1'b0, 1'b1, a, 8'h00};
      q.push_back(e);
   endtask

   // Drops every strobe, then lets that edge settle before outputs are looked at.
   task automatic idle();
      @(posedge mclk_in);
      req       <= '0;
      pix_valid <= 1'b0;
      #1;
   endtask

   // ==========================================================================
   // Read monitor
   // ==========================================================================
   // Read data lands at the taking edge itself; compare at the falling edge that follows.
   always @(posedge mclk_in) rd_d <= req.rd;
   always @(negedge mclk_in) begin
      if (rd_d === 1'b1) begin
         check(rdata, q.pop_front());
      end
   end

   // ==========================================================================
   // Verdict and watchdog
   // ==========================================================================
   task automatic give_verdict();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // The run needs some 110 cycles; 3000 cycles means a hang.
   initial begin
      #(25 * 3000);
      err_count++;
      give_verdict();
   end

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      reset_in = 1'b1;
      req = '0;
      pix_valid = 1'b0;
      pix = '0;
      up = 1'b0;
      cal = 10'h000;
      seed = 8'h2e;
      cases = '{{8'h10, 8'h81, 8'h10, 1'b1}, {8'h10, 8'h80, 8'h10, 1'b0},
                {8'h10, 8'h7f, 8'h10, 1'b1}, {8'hf8, 8'h80, 8'h10, 1'b1},
                {8'h10, 8'h80, 8'h05, 1'b0}, {8'hef, 8'h80, 8'hf0, 1'b1},
                {8'hef, 8'h80, 8'h10, 1'b1}};
      repeat (5) @(posedge mclk_in);
      reset_in <= 1'b0;
      // Reset values of every offset, then two unmapped ones.
      for (int i = 0; i < 8; i++) rd(PCR_ADDR_RED + i[7:0], rst[i]);
      rd(8'h46, 8'h00);
      rd(8'h3d, 8'h00);
      idle();
      check(rec, 7'h47);
      check(pp, 24'h000000);
      check(amt, 8'h00);
      // Back-to-back random writes, including the read-only and an unmapped place.
      for (int i = 0; i < 8; i++) begin
         d[i] = lfsr();
         wr(PCR_ADDR_RED + i[7:0], d[i]);
      end
      wr(8'h46, lfsr());
      for (int i = 0; i < 8; i++) begin
         rd(PCR_ADDR_RED + i[7:0], (i == 5) ? 8'h00 : (i == 7) ? {4'h0, d[7][3:0]} : d[i]);
      end
      idle();
      check(pp, {d[0], d[1], d[2]});
      check(amt, d[3]);
      check(rec, rec_of(d[6]));
      // Walk one set bit through the control register.
      for (int i = 0; i < 8; i++) begin
         wr(PCR_ADDR_CRCTL, 8'h01 << i);
         rd(PCR_ADDR_CRCTL, 8'h01 << i);
         idle();
         check(rec, rec_of(8'h01 << i));
      end
      // Phase offset with wrap past the top of the phase range, then a random phase.
      wr(PCR_ADDR_PHOFS, 8'hf5);
      @(posedge mclk_in);
      req <= '0;
      cal <= 10'h3fe;
      idle();
      check(fin, 10'h003);
      @(posedge mclk_in);
      cal <= {2'b10, lfsr()};
      idle();
      check(fin, cal + 10'h005);
      // Pixel compare and brightness range cases.
      wr(PCR_ADDR_BRIGHT, 8'h10);
      wr(PCR_ADDR_CMPREF, 8'h80);
      rd(PCR_ADDR_CMPREF, 8'h80);
      for (int i = 0; i < 7; i++) begin
         @(posedge mclk_in);
         req       <= '0;
         pix_valid <= 1'b1;
         pix       <= cases[i][24:1];
         up        <= cases[i][0];
         idle();
         rd(PCR_ADDR_STATUS, st_of(cases[i], 8'h10, 8'h80));
         // Without a strobe the status must not follow the pixel lines.
         @(posedge mclk_in);
         req <= '0;
         pix <= ~cases[i][24:1];
         wr(PCR_ADDR_STATUS, 8'hff);
         rd(PCR_ADDR_STATUS, st_of(cases[i], 8'h10, 8'h80));
      end
      repeat (3) idle();
      give_verdict();
   end
endmodule
